// [rtl/ehf_defines.svh]
// offsets, field positions, reset values and counts of the event header formatter
`ifndef EHF_DEFINES_SVH
`define EHF_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EHF_REG_CTRL 8'h00
`define EHF_REG_ID 8'h04
`define EHF_REG_USER 8'h08
`define EHF_REG_WLEN 8'h0c
`define EHF_REG_STATUS 8'h10
// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define EHF_CTRL_CFD 0
`define EHF_CTRL_ACCEPT_ALL 1
`define EHF_CTRL_TTS 2
`define EHF_CTRL_MULTIPLEXED_FIELD_MODE_FLAG 3
`define EHF_CTRL_P2M 4
`define EHF_CTRL_RESET 5'h00
// ----------------------------------------------------------------
// header constants
// ----------------------------------------------------------------
`define EHF_SYNC_WORD 32'haaaaaaaa
`define EHF_HDR_WORDS 11'h00e
`define EHF_HDR_LAST 4'hd
`define EHF_TYPE_LEADING 4'h7
`define EHF_TYPE_CFD 4'h8
`define EHF_BASELINE_NS 10240
`define EHF_CLK_NS 10
`define EHF_BASELINE_CYC (`EHF_BASELINE_NS / `EHF_CLK_NS)
`endif

// [rtl/ehf_pkg.sv]
// types of the event header formatter
package ehf_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_ACCEPT, ST_SEND, ST_WAVE} ehf_state_type;

  typedef struct packed {
    logic fire;
    logic coarse_fire;
    logic peak_found;
    logic holdoff_done;
    logic preamp_reset;
    logic cfd_valid;
    logic pileup_flag;
    logic second_thr;
    logic [3:0] stacked_hit_count;
    logic [23:0] post_sum;
    logic [23:0] pre_sum;
    logic [23:0] p2_sum;
    logic [23:0] base_sum;
    logic [23:0] early_sum;
    logic [23:0] early2_sum;
    logic [13:0] cfd0;
    logic [13:0] cfd1;
    logic [13:0] cfd2;
  } ehf_hit_type;

  typedef struct packed {
    logic accept;
    logic [2:0] ev_type;
    logic [15:0] trigger_detector_info;
    logic [7:0] mult_x;
    logic [7:0] mult_y;
    logic [15:0] msg_ts;
  } ehf_trig_type;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [31:0] data;
  } ehf_out_type;

  typedef struct packed {
    ehf_state_type st;
    logic [4:0] ctrl;
    logic [4:0] geo;
    logic [3:0] chan;
    logic [11:0] user;
    logic [9:0] wlen;
    logic [15:0] evcnt;
    logic [31:0] rdata;
    ehf_out_type out;
    logic [3:0] idx;
    logic [9:0] wcnt;
    logic [47:0] last_ts;
    logic [23:0] last_post;
    logic last_cv;
    logic [47:4] rst_ts;
    logic [23:0] pend_early;
    logic [9:0] pend_coarse;
    logic pend_cf;
    logic [47:0] ts;
    logic [47:0] prev_ts;
    logic [23:0] prev_post;
    logic [23:0] post;
    logic [23:0] pre;
    logic [23:0] p2;
    logic [23:0] base;
    logic [23:0] early;
    logic [23:0] mux;
    logic [9:0] coarse_ts;
    logic cf;
    logic [15:0] peak_ts;
    logic peak_found_flag;
    logic reset_timestamp_match_flag;
    logic cfd;
    logic cv;
    logic pcv;
    logic tsm;
    logic pf;
    logic second_thr;
    logic [3:0] pile;
    logic [13:0] cfd0;
    logic [13:0] cfd1;
    logic [13:0] cfd2;
    logic [2:0] ev_type;
    logic [15:0] det;
    logic [7:0] mx;
    logic [7:0] my;
    logic [15:0] trig_ts;
  } ehf_regs_type;
endpackage

// [rtl/ehf_formatter.sv]
// event header formatter: latches hit data and emits header plus waveform words
//
// Overview of operation
// - header word 1 carries the crate slot number from the id register.
// - packet length equals header words plus waveform words.
// - user packet register value copied unchanged into every header.
// - channel identifier from the id register placed in every header.
// - header length is fourteen; the rest of the packet is waveform.
// - event type comes from the accept message, zero in accept-all mode.
// - header type is 7 in leading-edge mode, 8 in constant-fraction mode.
// - post-rise and pre-rise sums latched at main discriminator firing.
// - extended post-rise sum latched at main discriminator firing.
// - early pre-rise sum captured earlier, at coarse discriminator firing.
// - 10.24 us baseline sum latched at main discriminator firing.
// - event timestamp is the full 48-bit counter at firing.
// - previous firing timestamp kept on every firing, read out or not.
// - low 16 counter bits recorded when the peak detector finds a peak.
// - peak found flag stays clear if no peak before holdoff ends.
// - low 10 counter bits latched at coarse firing reported in header.
// - multiplexed field may hold preamp reset timestamp bits 27:4.
// - match flag set when reset and event timestamp bits 47:28 agree.
// - multiplexed mode flag is the control bit at readout; the field follows that bit at firing.
// - source flag 0 puts local counter at message arrival in trigger field, or at holdoff end in accept-all mode.
// - outside accept-all mode, source flag 1 puts message timestamp low 16 bits in trigger field.
// - trigger detector data placed in header; the two 8-bit multiplicities only in leading-edge mode.
// - header type is four bits, event type three bits, in word 3.
// - every output word is exactly 32 bits wide.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ehf_defines.svh"
module ehf_formatter
  import ehf_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output var logic [31:0] RDATA_O,
  // channel pipeline and trigger
  input wire logic [47:0] TS_I,
  input wire ehf_hit_type HIT_I,
  input wire ehf_trig_type TRIG_I,
  // waveform words from the channel fifo
  input wire logic WAVE_VALID_I,
  input wire logic [31:0] WAVE_DATA_I,
  // packet to the accepted-event fifo
  output var ehf_out_type OUT_O
);

  ehf_regs_type s;
  ehf_regs_type next_s;

  // ----------------------------------------------------------------
  // header word selection
  // ----------------------------------------------------------------
  function automatic logic [31:0] hdr_word(input ehf_regs_type r, input logic [3:0] i);
    logic [10:0] plen;
    logic [31:0] w;
    plen = `EHF_HDR_WORDS + {1'b0, r.wlen};
    w = 32'h00000000;
    case (i)
      4'h0: w = `EHF_SYNC_WORD;
      4'h1: w = {r.geo, plen, r.user, r.chan};
      4'h2: w = r.ts[31:0];
      4'h3: begin
        w = {6'(`EHF_HDR_WORDS), r.ev_type, 1'b0, r.ctrl[`EHF_CTRL_TTS],
             r.ctrl[`EHF_CTRL_ACCEPT_ALL], (r.cfd ? `EHF_TYPE_CFD : `EHF_TYPE_LEADING),
             r.ts[47:32]};
      end
      4'h4: begin
        w = {r.prev_ts[15:0], r.pf, 1'b0, 1'b0, 1'b0, r.cv, 1'b0, r.peak_found_flag,
             1'b0, r.tsm, 1'b0, 1'b0, 1'b0, (r.cfd ? r.det[15:12] : 4'h0)};
      end
      4'h5: begin
        if (r.cfd) begin
          w = {r.det[11:10], r.cfd0, r.det[9:8], r.prev_ts[29:16]};
        end else begin
          w = r.prev_ts[47:16];
        end
      end
      4'h6: begin
        if (r.cfd) begin
          w = {r.det[7:0], r.base};
        end else begin
          w = {4'h0, r.pile, r.base};
        end
      end
      4'h7: begin
        if (r.cfd) begin
          w = {r.pile[3:2], r.cfd2, r.pile[1:0], r.cfd1};
        end else begin
          w = {r.det, r.mx, r.my};
        end
      end
      4'h8: w = {r.post[7:0], r.pre};
      4'h9: w = {r.peak_ts, r.post[23:8]};
      4'ha: begin
        w = {r.trig_ts, r.ctrl[`EHF_CTRL_MULTIPLEXED_FIELD_MODE_FLAG], r.ctrl[`EHF_CTRL_P2M], r.p2[13:0]};
      end
      4'hb: w = {r.prev_post[23:16], r.mux};
      4'hc: w = {r.prev_post[15:8], r.early};
      4'hd: begin
        w = {r.prev_post[7:0], r.coarse_ts, r.cf, r.pcv, r.reset_timestamp_match_flag,
             r.second_thr, r.p2[23:14]};
      end
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.out.valid = 1'b0;
    next_s.out.first = 1'b0;
    next_s.out.last = 1'b0;
    next_s.rdata = 32'h00000000;

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        `EHF_REG_CTRL: next_s.ctrl = WDATA_I[4:0];
        `EHF_REG_ID: begin
          next_s.chan = WDATA_I[3:0];
          next_s.geo = WDATA_I[12:8];
        end
        `EHF_REG_USER: next_s.user = WDATA_I[11:0];
        `EHF_REG_WLEN: next_s.wlen = WDATA_I[9:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end

    // register reads, data in the following cycle
    if (RD_I) begin
      case (ADDR_I)
        `EHF_REG_CTRL: next_s.rdata = {27'h0000000, s.ctrl};
        `EHF_REG_ID: next_s.rdata = {19'h00000, s.geo, 4'h0, s.chan};
        `EHF_REG_USER: next_s.rdata = {20'h00000, s.user};
        `EHF_REG_WLEN: next_s.rdata = {22'h000000, s.wlen};
        `EHF_REG_STATUS: begin
          next_s.rdata = {s.evcnt, 13'h0000, (s.st != ST_IDLE), s.peak_found_flag, s.cf};
        end
        default: next_s.rdata = 32'h00000000;
      endcase
    end

    // coarse discriminator: early sum and coarse time ahead of the main hit
    if (HIT_I.coarse_fire) begin
      next_s.pend_early = HIT_I.early_sum;
      next_s.pend_coarse = TS_I[9:0];
      next_s.pend_cf = 1'b1;
    end

    // preamp reset time, kept down to 160 ns resolution
    if (HIT_I.preamp_reset) begin
      next_s.rst_ts = TS_I[47:4];
    end

    // every main firing updates the carry-forward history
    if (HIT_I.fire) begin
      next_s.last_ts = TS_I;
      next_s.last_post = HIT_I.post_sum;
      next_s.last_cv = HIT_I.cfd_valid;
    end

    case (s.st)
      ST_IDLE: begin
        if (HIT_I.fire) begin
          next_s.st = ST_HOLD;
          next_s.ts = TS_I;
          next_s.prev_ts = s.last_ts;
          next_s.prev_post = s.last_post;
          next_s.pcv = s.last_cv;
          next_s.post = HIT_I.post_sum;
          next_s.pre = HIT_I.pre_sum;
          next_s.p2 = HIT_I.p2_sum;
          next_s.base = HIT_I.base_sum;
          next_s.early = HIT_I.coarse_fire ? HIT_I.early_sum : s.pend_early;
          next_s.coarse_ts = HIT_I.coarse_fire ? TS_I[9:0] : s.pend_coarse;
          next_s.cf = HIT_I.coarse_fire | s.pend_cf;
          next_s.pend_cf = 1'b0;
          if (s.ctrl[`EHF_CTRL_MULTIPLEXED_FIELD_MODE_FLAG]) begin
            next_s.mux = s.rst_ts[27:4];
          end else begin
            next_s.mux = HIT_I.early2_sum;
          end
          next_s.reset_timestamp_match_flag = (s.rst_ts[47:28] == TS_I[47:28]);
          next_s.cfd = s.ctrl[`EHF_CTRL_CFD];
          next_s.cv = s.ctrl[`EHF_CTRL_CFD] & HIT_I.cfd_valid;
          next_s.tsm = s.ctrl[`EHF_CTRL_CFD] & (s.last_ts[47:30] == TS_I[47:30]);
          next_s.pf = HIT_I.pileup_flag;
          next_s.second_thr = HIT_I.second_thr;
          next_s.pile = HIT_I.stacked_hit_count;
          next_s.cfd0 = HIT_I.cfd0;
          next_s.cfd1 = HIT_I.cfd1;
          next_s.cfd2 = HIT_I.cfd2;
          next_s.peak_found_flag = 1'b0;
          next_s.peak_ts = 16'h0000;
        end
      end
      ST_HOLD: begin
        if (HIT_I.peak_found && !s.peak_found_flag) begin
          next_s.peak_found_flag = 1'b1;
          next_s.peak_ts = TS_I[15:0];
        end
        if (HIT_I.holdoff_done) begin
          if (s.ctrl[`EHF_CTRL_ACCEPT_ALL]) begin
            next_s.ev_type = 3'h0;
            next_s.det = 16'h0000;
            next_s.mx = 8'h00;
            next_s.my = 8'h00;
            next_s.trig_ts = TS_I[15:0];
            next_s.idx = 4'h0;
            next_s.st = ST_SEND;
          end else begin
            next_s.st = ST_ACCEPT;
          end
        end
      end
      ST_ACCEPT: begin
        if (TRIG_I.accept) begin
          next_s.ev_type = TRIG_I.ev_type;
          next_s.det = TRIG_I.trigger_detector_info;
          next_s.mx = TRIG_I.mult_x;
          next_s.my = TRIG_I.mult_y;
          if (s.ctrl[`EHF_CTRL_TTS]) begin
            next_s.trig_ts = TRIG_I.msg_ts;
          end else begin
            next_s.trig_ts = TS_I[15:0];
          end
          next_s.idx = 4'h0;
          next_s.st = ST_SEND;
        end
      end
      ST_SEND: begin
        next_s.out.valid = 1'b1;
        next_s.out.first = (s.idx == 4'h0);
        next_s.out.data = hdr_word(s, s.idx);
        if (s.idx == `EHF_HDR_LAST) begin
          next_s.wcnt = 10'h000;
          next_s.evcnt = s.evcnt + 16'h0001;
          if (s.wlen == 10'h000) begin
            next_s.out.last = 1'b1;
            next_s.st = ST_IDLE;
          end else begin
            next_s.st = ST_WAVE;
          end
        end else begin
          next_s.idx = s.idx + 4'h1;
        end
      end
      ST_WAVE: begin
        if (WAVE_VALID_I) begin
          next_s.out.valid = 1'b1;
          next_s.out.data = WAVE_DATA_I;
          next_s.wcnt = s.wcnt + 10'h001;
          if (s.wcnt == s.wlen - 10'h001) begin
            next_s.out.last = 1'b1;
            next_s.st = ST_IDLE;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= `EHF_CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA_O = s.rdata;
  assign OUT_O = s.out;

endmodule
`default_nettype wire

// [test/ehf_fifo_model.sv]
// sink model of the accepted-event fifo behind the formatter
`timescale 1ns/1ps
`default_nettype none
module ehf_fifo_model
  import ehf_pkg::*;
(
  // clock and packet in
  input wire logic clk_i,
  input wire ehf_out_type pkt_i
);
  // ----------------------------------------------------------------
  // word store, never stalls
  // ----------------------------------------------------------------
  logic [31:0] w [0:63];
  int n = 0;
  int n_last = 0;
  always @(posedge clk_i) begin
    if (pkt_i.valid) begin
      w[pkt_i.first ? 0 : n % 64] <= pkt_i.data;
      n <= pkt_i.first ? 1 : n + 1;
      if (pkt_i.first) begin
        n_last <= 0;
      end
      if (pkt_i.last) begin
        n_last <= pkt_i.first ? 1 : n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/ehf_formatter_sva.sv]
// port assertions of the event header formatter
`timescale 1ns/1ps
`default_nettype none
`include "ehf_defines.svh"
module ehf_formatter_sva
  import ehf_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  // packet out
  input wire ehf_out_type OUT_O
);
  // ----------------------------------------------------------------
  // register mirror and properties
  // ----------------------------------------------------------------
  logic [4:0] ctrl;
  logic [12:0] id;
  logic [11:0] user;
  logic [9:0] wlen;
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      ctrl <= 5'h00;
      id <= 13'h0000;
      user <= 12'h000;
      wlen <= 10'h000;
    end else if (WR_I) begin
      if (ADDR_I == `EHF_REG_CTRL) ctrl <= WDATA_I[4:0];
      if (ADDR_I == `EHF_REG_ID) id <= WDATA_I[12:0];
      if (ADDR_I == `EHF_REG_USER) user <= WDATA_I[11:0];
      if (ADDR_I == `EHF_REG_WLEN) wlen <= WDATA_I[9:0];
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  sync_word_a: assert property (OUT_O.first |-> OUT_O.valid && OUT_O.data == 32'haaaaaaaa)
    else $error("packet start without sync word");
  header_run_a: assert property (OUT_O.first |-> OUT_O.valid[*8] ##1 OUT_O.valid[*6])
    else $error("header words not contiguous");
  ident_word_a: assert property (OUT_O.first |=>
    OUT_O.data == {id[12:8], 11'h00e + {1'b0, wlen}, user, id[3:0]}) else $error("bad word 1");
  mode_word_a: assert property (OUT_O.first |-> ##3 OUT_O.data[31:26] == 6'h0e &&
    OUT_O.data[19:16] == (ctrl[0] ? 4'h8 : 4'h7)) else $error("bad word 3");
  evtype_zero_a: assert property (OUT_O.first && ctrl[1] |-> ##3
    OUT_O.data[25:23] == 3'h0 && OUT_O.data[20]) else $error("event type not zero");
  tts_flag_a: assert property (OUT_O.first |-> ##3 OUT_O.data[21] == ctrl[2])
    else $error("source flag wrong");
  mux_mode_a: assert property (OUT_O.first |-> ##10 OUT_O.data[15:14] == {ctrl[3], ctrl[4]})
    else $error("mode flags wrong");
  rdata_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside read slot");
  cover property (OUT_O.first && ctrl[0]);
  cover property (OUT_O.first && ctrl[1]);
  cover property (RD_I ##1 RDATA_O != 32'h0);
endmodule
bind ehf_formatter ehf_formatter_sva chk (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .OUT_O(OUT_O));
`default_nettype wire

// [test/ehf_formatter_tb.sv]
// self-checking bench of the event header formatter
`timescale 1ns/1ps
`default_nettype none
module ehf_formatter_tb
  import ehf_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, tasks and tests
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wave_valid = 1'b0;
  logic [31:0] rdata;
  logic [47:0] ts = 48'h1234_5670_0000;
  ehf_hit_type hit = '0;
  ehf_trig_type trig = '0;
  ehf_out_type out;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [47:0] tf1, tf, tp, ta, tc, tr;
  ehf_formatter uut (.CORE_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TS_I(ts), .HIT_I(hit), .TRIG_I(trig),
    .WAVE_VALID_I(wave_valid), .WAVE_DATA_I(ts[31:0]), .OUT_O(out));
  ehf_fifo_model p (.clk_i(clk), .pkt_i(out));
  always #5 clk = ~clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ts <= ts + 48'h1;
    wave_valid <= ~wave_valid;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task automatic run_event(input bit pk, input bit acc);
    int k;
    @(posedge clk);
    hit.coarse_fire <= 1'b1;
    #1 tc = ts;
    @(posedge clk);
    hit.coarse_fire <= 1'b0;
    hit.fire <= 1'b1;
    #1 tf = ts;
    @(posedge clk);
    hit.fire <= 1'b0;
    hit.peak_found <= pk;
    #1 tp = ts;
    @(posedge clk);
    hit.peak_found <= 1'b0;
    hit.holdoff_done <= 1'b1;
    @(posedge clk);
    hit.holdoff_done <= 1'b0;
    trig.accept <= acc;
    #1 ta = ts;
    @(posedge clk);
    trig.accept <= 1'b0;
    k = 0;
    while (k < 100 && !(out.valid === 1'b1 && out.last === 1'b1)) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
    #1 chk("packet length", 32'd17, p.n_last);
    chk("wave order", p.w[14] + 32'h2, p.w[15]);
  endtask
  initial begin
    hit.post_sum = 24'h1a2b3c;
    hit.pre_sum = 24'h0d0e0f;
    hit.p2_sum = 24'h2468ac;
    hit.base_sum = 24'h5a5a5a;
    hit.early_sum = 24'h0c0ffe;
    hit.cfd0 = 14'h1555;
    hit.early2_sum = 24'h3c3c3c;
    hit.cfd_valid = 1'b1;
    trig.ev_type = 3'h5;
    trig.trigger_detector_info = 16'hbeef;
    trig.mult_x = 8'h12;
    trig.mult_y = 8'h34;
    trig.msg_ts = 16'h4321;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h00, 32'h0, "ctrl reset");
    wr_reg(8'h04, 32'h0b06);
    wr_reg(8'h08, 32'h0abc);
    wr_reg(8'h0c, 32'h3);
    wr_reg(8'h20, 32'hffff);
    rd_reg(8'h04, 32'h0b06, "id");
    rd_reg(8'h08, 32'h0abc, "user");
    rd_reg(8'h20, 32'h0, "unmapped");
    run_event(1'b1, 1'b1);
    chk("sync", 32'haaaaaaaa, p.w[0]);
    chk("ident", {5'h0b, 11'h011, 12'habc, 4'h6}, p.w[1]);
    chk("ts low", tf[31:0], p.w[2]);
    chk("mode", {6'h0e, 3'h5, 3'h0, 4'h7, tf[47:32]}, p.w[3]);
    chk("peak flag", 32'h1, {31'h0, p.w[4][9]});
    chk("baseline", 32'h5a5a5a, p.w[6][23:0]);
    chk("trigger info", 32'hbeef1234, p.w[7]);
    chk("sums", {8'h3c, 24'h0d0e0f}, p.w[8]);
    chk("peak time", {tp[15:0], 16'h1a2b}, p.w[9]);
    chk("trigger time", {ta[15:0], 2'b00, 14'h28ac}, p.w[10]);
    chk("early sum", 32'h0c0ffe, p.w[12][23:0]);
    chk("coarse", {tc[9:0], 4'b1000, 10'h091}, p.w[13][23:0]);
    chk("early2 sum", 32'h3c3c3c, p.w[11][23:0]);
    chk("led flags", 32'h0, {26'h0, p.w[4][11], p.w[4][7], p.w[4][3:0]});
    rd_reg(8'h10, 32'h00010003, "status");
    tf1 = tf;
    wr_reg(8'h00, 32'h2);
    run_event(1'b0, 1'b0);
    chk("accept all", {6'h0e, 3'h0, 3'h1, 4'h7, tf[47:32]}, p.w[3]);
    chk("peak clear", 32'h0, {31'h0, p.w[4][9]});
    chk("prev ts low", tf1[15:0], p.w[4][31:16]);
    chk("prev ts high", tf1[47:16], p.w[5]);
    chk("prev post", 32'h1a2b3c, {8'h0, p.w[11][31:24], p.w[12][31:24], p.w[13][31:24]});
    wr_reg(8'h00, 32'h1d);
    tf1 = tf;
    @(posedge clk);
    hit.preamp_reset <= 1'b1;
    #1 tr = ts;
    @(posedge clk);
    hit.preamp_reset <= 1'b0;
    run_event(1'b1, 1'b1);
    chk("cfd mode", {6'h0e, 3'h5, 3'h2, 4'h8, tf[47:32]}, p.w[3]);
    chk("msg time", {16'h4321, 2'b11}, p.w[10][31:14]);
    chk("cfd sample", 14'h1555, p.w[5][29:16]);
    chk("reset time", tr[27:4], p.w[11][23:0]);
    chk("reset match", 32'h1, {31'h0, p.w[13][11]});
    chk("cfd flags", 32'h7, {29'h0, p.w[4][11], p.w[4][7], p.w[13][12]});
    chk("cfd det", 32'hbeef, {16'h0, p.w[4][3:0], p.w[5][31:30], p.w[5][15:14], p.w[6][31:24]});
    chk("cfd prev ts", tf1[29:16], p.w[5][13:0]);
    end_of_test;
  end
endmodule
`default_nettype wire
